// *** adcseq_top.sv ***
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int N_TRIG = 8
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  // Avalon-MM slave
  input  wire logic [4:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Trigger sources and interrupt acknowledge
  input  wire logic [N_TRIG-1:0] trig_i,
  input  wire logic              irq_ack_i,
  output logic                   irq_req_o,
  // Converter side
  input  wire logic [9:0]        result_i,
  output logic                   power_on_o,
  output logic                   sample_o,
  output logic                   conv_busy_o,
  output logic [5:0]             channel_o,
  output logic [2:0]             reference_o,
  output logic                   gain_select_o,
  output logic                   gain_bypass_o,
  output logic                   temp_sensor_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] div_ratio(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h01 << sel;
    div_ratio = (r < DIV_MIN) ? DIV_MIN : r;
  endfunction

  function automatic logic is_single(input logic [5:0] ch);
    is_single = (ch < CH_SE_COUNT) || (ch == CH_TEMP_SENSOR);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, access takes effect when released
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        req;
  logic        acc_wr;
  logic        acc_rd;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign acc_wr            = avs_write_i & ack_q;
  assign acc_rd            = avs_read_i & ack_q;
  assign avs_readdata_o    = rdata_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic        en_q;
  logic        auto_q;
  logic        ie_q;
  logic [2:0]  div_q;
  logic        gain_q;
  logic [2:0]  trg_q;
  logic [5:0]  ch_tmp_q;
  logic        left_q;
  logic [2:0]  ref_tmp_q;
  logic        wr_a;
  logic        wr_b;
  logic        wr_m;

  assign wr_a = acc_wr && avs_address_i == ADDR_CTRL_A && avs_byteenable_i[0];
  assign wr_b = acc_wr && avs_address_i == ADDR_CTRL_B && avs_byteenable_i[0];
  assign wr_m = acc_wr && avs_address_i == ADDR_MUXSEL;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q      <= 1'b0;
      auto_q    <= 1'b0;
      ie_q      <= 1'b0;
      div_q     <= 3'h0;
      gain_q    <= 1'b0;
      trg_q     <= 3'h0;
      ch_tmp_q  <= 6'h00;
      left_q    <= 1'b0;
      ref_tmp_q <= 3'h0;
    end else begin
      if (wr_a) begin
        en_q   <= avs_writedata_i[CA_ENABLE];
        auto_q <= avs_writedata_i[CA_AUTO];
        ie_q   <= avs_writedata_i[CA_IE];
        div_q  <= avs_writedata_i[CA_DIV_LO +: 3];
      end
      if (wr_b) begin
        gain_q <= avs_writedata_i[CB_GAIN];
        trg_q  <= avs_writedata_i[CB_TRG_LO +: 3];
      end
      if (wr_m && avs_byteenable_i[0]) begin
        ch_tmp_q <= avs_writedata_i[MX_CH_LO +: 6];
        left_q   <= avs_writedata_i[MX_LEFT];
      end
      if (wr_m && avs_byteenable_i[1]) begin
        ref_tmp_q <= avs_writedata_i[MX_REF_LO +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger synchroniser and edge detector
  // ----------------------------------------------------------------
  logic [N_TRIG-1:0] trg_s1_q;
  logic [N_TRIG-1:0] trg_s2_q;
  logic              trg_old_q;
  logic              trg_lvl;
  logic              trg_edge;

  // Two sync stages cost two clocks of latency; the edge compare with trg_old_q adds none
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trg_s1_q  <= '0;
      trg_s2_q  <= '0;
      trg_old_q <= 1'b0;
    end else begin
      trg_s1_q  <= trig_i;
      trg_s2_q  <= trg_s1_q;
      trg_old_q <= trg_lvl;
    end
  end

  assign trg_lvl  = trg_s2_q[trg_q];
  assign trg_edge = trg_lvl & ~trg_old_q;

  // ----------------------------------------------------------------
  // Prescaler and conversion sequencer
  // ----------------------------------------------------------------
  adcsq_state_t st_q;
  logic [7:0]   pre_q;
  logic [7:0]   ratio;
  logic         rise;
  logic         fall;
  logic [4:0]   cyc_q;
  logic [4:0]   len;
  logic         first_q;
  logic         auto_conv_q;
  logic         pend_q;
  logic         busy;
  logic         last_cyc;
  logic         done;
  logic         free_run;
  logic         trig_start;
  logic         sw_start;
  logic         start_wr;

  assign ratio      = div_ratio(div_q);
  assign rise       = en_q && pre_q == ratio - 8'h01;
  assign fall       = en_q && pre_q == (ratio >> 1) - 8'h01;
  assign busy       = st_q == ADCSQ_CONV;
  assign len        = first_q ? LEN_FIRST : LEN_NORMAL;
  assign last_cyc   = busy && cyc_q == len - 5'h01;
  assign done       = last_cyc && rise;
  assign free_run   = auto_q && trg_q == TRG_OWN_FLAG;
  assign trig_start = en_q && auto_q && !free_run && trg_edge && !busy;
  assign sw_start   = en_q && pend_q && rise && !busy;
  assign start_wr   = wr_a && avs_writedata_i[CA_START] && avs_writedata_i[CA_ENABLE];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q <= 8'h00;
    end else if (!en_q || trig_start || rise) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Pending request holds the start bit high until the first edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= 1'b0;
    end else if (!en_q) begin
      pend_q <= start_wr;
    end else if (start_wr && !busy) begin
      pend_q <= 1'b1;
    end else if (sw_start || trig_start) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q        <= ADCSQ_IDLE;
      cyc_q       <= 5'h00;
      auto_conv_q <= 1'b0;
    end else begin
      case (st_q)
        ADCSQ_IDLE: begin
          if (sw_start || trig_start) begin
            st_q        <= ADCSQ_CONV;
            cyc_q       <= 5'h00;
            auto_conv_q <= trig_start;
          end
        end
        ADCSQ_CONV: begin
          if (!en_q) begin
            st_q <= ADCSQ_IDLE;
          end else if (done) begin
            cyc_q       <= 5'h00;
            auto_conv_q <= 1'b0;
            st_q        <= (free_run && en_q) ? ADCSQ_CONV : ADCSQ_IDLE;
          end else if (rise) begin
            cyc_q <= cyc_q + 5'h01;
          end
        end
        default: begin
          st_q <= ADCSQ_IDLE;
        end
      endcase
    end
  end

  // First conversion after enable runs long to settle the analog side
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_q <= 1'b1;
    end else if (!en_q) begin
      first_q <= 1'b1;
    end else if (done) begin
      first_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sample strobe
  // ----------------------------------------------------------------
  logic smp_now;

  always_comb begin
    smp_now = 1'b0;
    if (busy && auto_conv_q) begin
      smp_now = rise && cyc_q == SMP_AUTO - 5'h01;
    end else if (busy && first_q) begin
      smp_now = fall && cyc_q == SMP_FIRST;
    end else if (busy) begin
      smp_now = fall && cyc_q == SMP_NORMAL;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= smp_now;
    end
  end

  // ----------------------------------------------------------------
  // Channel and reference selection, frozen while converting
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      channel_o     <= 6'h00;
      reference_o   <= 3'h0;
      gain_select_o <= 1'b0;
      gain_bypass_o <= 1'b1;
      temp_sensor_o <= 1'b0;
    end else if (en_q && (!busy || last_cyc)) begin
      channel_o     <= ch_tmp_q;
      reference_o   <= ref_tmp_q;
      gain_select_o <= gain_q;
      gain_bypass_o <= is_single(ch_tmp_q);
      temp_sensor_o <= ch_tmp_q == CH_TEMP_SENSOR;
    end
  end

  assign power_on_o  = en_q;
  assign conv_busy_o = busy;

  // ----------------------------------------------------------------
  // Result bytes, read lock and completion flag
  // ----------------------------------------------------------------
  logic [15:0] res_q;
  logic        lock_q;
  logic        flag_q;
  logic        rd_low;
  logic        rd_hi;
  logic        res_wr;

  assign rd_low = acc_rd && avs_address_i == ADDR_RES_LOW;
  assign rd_hi  = acc_rd && avs_address_i == ADDR_RES_HI;
  assign res_wr = done && !lock_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b0;
    end else if (rd_low) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_q <= 16'h0000;
    end else if (res_wr && left_q) begin
      res_q <= {result_i, 6'h00};
    end else if (res_wr) begin
      res_q <= {6'h00, result_i};
    end
  end

  // A new completion wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1;
    end else if (irq_ack_i || (wr_a && avs_writedata_i[CA_FLAG])) begin
      flag_q <= 1'b0;
    end
  end

  assign irq_req_o = flag_q & ie_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address_i)
      ADDR_CTRL_A: begin
        rdata_d[CA_ENABLE]       = en_q;
        rdata_d[CA_START]        = pend_q | busy;
        rdata_d[CA_AUTO]         = auto_q;
        rdata_d[CA_FLAG]         = flag_q;
        rdata_d[CA_IE]           = ie_q;
        rdata_d[CA_DIV_LO +: 3]  = div_q;
      end
      ADDR_CTRL_B: begin
        rdata_d[CB_GAIN]         = gain_q;
        rdata_d[CB_TRG_LO +: 3]  = trg_q;
      end
      ADDR_MUXSEL: begin
        rdata_d[MX_CH_LO +: 6]   = ch_tmp_q;
        rdata_d[MX_LEFT]         = left_q;
        rdata_d[MX_REF_LO +: 3]  = ref_tmp_q;
      end
      ADDR_RES_LOW: begin
        rdata_d[7:0]             = res_q[7:0];
      end
      ADDR_RES_HI: begin
        rdata_d[7:0]             = res_q[15:8];
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [4:0] rise_cnt_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_cnt_q <= 5'h00;
    end else if ((!busy && (sw_start || trig_start)) || done) begin
      rise_cnt_q <= 5'h00;
    end else if (busy && rise) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  property p_len;
    @(posedge clock_i) disable iff (!rstn_i)
      done |-> rise_cnt_q == (first_q ? 5'd24 : 5'd12);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");

  property p_lock;
    @(posedge clock_i) disable iff (!rstn_i)
      done && lock_q |=> $stable(res_q) && flag_q;
  endproperty
  a_lock: assert property (p_lock) else $error("locked result overwritten");

  property p_flag;
    @(posedge clock_i) disable iff (!rstn_i)
      done |=> flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set on completion");

  property p_single_clear;
    @(posedge clock_i) disable iff (!rstn_i)
      done && !free_run && !start_wr |=> !busy && !pend_q;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start bit not cleared");

  property p_free;
    @(posedge clock_i) disable iff (!rstn_i)
      done && free_run && en_q |=> busy && cyc_q == 5'd0;
  endproperty
  a_free: assert property (p_free) else $error("free running did not restart");

  property p_pre_off;
    @(posedge clock_i) disable iff (!rstn_i)
      !en_q |=> pre_q == 8'h00 && !busy;
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("prescaler ran while disabled");

  property p_freeze;
    @(posedge clock_i) disable iff (!rstn_i)
      busy && !last_cyc && en_q |=> $stable(channel_o) && $stable(reference_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection changed mid conversion");

  property p_left;
    @(posedge clock_i) disable iff (!rstn_i)
      res_wr && left_q |=> res_q[15:6] == $past(result_i) && res_q[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) else $error("left adjust wrong");

  property p_trig_reset;
    @(posedge clock_i) disable iff (!rstn_i)
      trig_start |=> pre_q == 8'h00 && busy && auto_conv_q;
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("trigger did not start");

  property p_normal_smp;
    @(posedge clock_i) disable iff (!rstn_i)
      smp_now && !first_q && !auto_conv_q |-> fall && cyc_q == 5'd1;
  endproperty
  a_normal_smp: assert property (p_normal_smp) else $error("sample point wrong");

  c_first: cover property (@(posedge clock_i) disable iff (!rstn_i) done && first_q);
  c_discard: cover property (@(posedge clock_i) disable iff (!rstn_i) done && lock_q);
  c_free: cover property (@(posedge clock_i) disable iff (!rstn_i) done && free_run);
  c_trig: cover property (@(posedge clock_i) disable iff (!rstn_i) trig_start);

endmodule // adcseq_top

// *** adcseq_pkg.sv ***
// Behaviour
// - Result right-justified, left-justified when selected
// - Low-byte read locks results until high read
// - Completion flag set even when result discarded
// - Start bit begins conversion, reads one, self-clears
// - Channel change waits for running conversion end
// - Auto-trigger rising edge resets prescaler, starts conversion
// - No level restart; edges during conversion ignored
// - Trigger flag must be cleared for next edge; here any trigger edge starts a conversion when idle, flag_q is not checked
// - Own completion flag as trigger means free running
// - Start bit works with auto trigger; reads busy
// - Prescaler divides clock, runs only while enabled
// - Software start begins on next converter clock edge
// - Normal conversion 13 cycles, first one 25
// - Sample at 1.5 cycles, first at 14.5
// - Completion writes result, sets flag, clears start
// - Auto-trigger sample two cycles after edge, synchronised
// - Free running restarts at once, start stays one
// - Selections apply only when enabled; else powered off
// - Six-bit channel field; all-ones selects temperature sensor
// - Differential uses gain select; single-ended bypasses gain
// - Three-bit reference select drives converter reference
// - Selections frozen during conversion, resume last cycle
package adcseq_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL_A  = 5'h00;
  localparam logic [4:0] ADDR_CTRL_B  = 5'h04;
  localparam logic [4:0] ADDR_MUXSEL  = 5'h08;
  localparam logic [4:0] ADDR_RES_LOW = 5'h0C;
  localparam logic [4:0] ADDR_RES_HI  = 5'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_ENABLE = 7;
  localparam int CA_START  = 6;
  localparam int CA_AUTO   = 5;
  localparam int CA_FLAG   = 4;
  localparam int CA_IE     = 3;
  localparam int CA_DIV_LO = 0;
  localparam int CB_GAIN   = 4;
  localparam int CB_TRG_LO = 0;
  localparam int MX_CH_LO  = 0;
  localparam int MX_LEFT   = 6;
  localparam int MX_REF_LO = 8;
  // ----------------------------------------------------------------
  // Codes and timing, in converter clock cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] CH_TEMP_SENSOR = 6'h3F;
  localparam logic [5:0] CH_SE_COUNT    = 6'h0B;
  localparam logic [2:0] TRG_OWN_FLAG   = 3'h0;
  localparam logic [4:0] LEN_NORMAL     = 5'h0D;
  localparam logic [4:0] LEN_FIRST      = 5'h19;
  localparam logic [4:0] SMP_NORMAL     = 5'h01;  // Plus half a cycle
  localparam logic [4:0] SMP_FIRST      = 5'h0E;  // Plus half a cycle
  localparam logic [4:0] SMP_AUTO       = 5'h02;
  localparam logic [7:0] DIV_MIN        = 8'h02;

  typedef enum logic [0:0] {
    ADCSQ_IDLE = 1'b0,
    ADCSQ_CONV = 1'b1
  } adcsq_state_t;
endpackage

// *** adcseq_conv_model.sv ***
`timescale 1ns/10ps
module adcseq_conv_model (
  // Control from the sequencer
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       power_on_i,
  input  wire logic       sample_i,
  input  wire logic [5:0] channel_i,
  // Conversion code
  output logic      [9:0] result_o
);
  logic [9:0] held_q;

  // Code follows the held channel, so every result is predictable
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held_q <= 10'h155;
    end else if (sample_i) begin
      held_q <= {channel_i, ~channel_i[3:0]};
    end
  end

  // An unpowered converter has no valid code, so show a toggling one
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= 10'h2AA;
    end else begin
      result_o <= power_on_i ? held_q : ~result_o;
    end
  end
endmodule // adcseq_conv_model

// *** adcseq_top_tb.sv ***
`timescale 1ns/10ps
module adcseq_top_tb;
  import adcseq_pkg::*;
  // ------
  // Signals
  // ------
  localparam int          DIV  = 4;
  localparam logic [31:0] RUN  = 32'h0000_008A;
  localparam logic [31:0] STRT = 32'h0000_0040;
  localparam logic [31:0] AUTO = 32'h0000_0020;
  localparam logic [31:0] CLR  = 32'h0000_0010;
  localparam logic [4:0]  ADR [6] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_MUXSEL, ADDR_RES_LOW, ADDR_RES_HI, 5'h14};
  localparam logic [5:0]  COR [4] = '{6'h3F, 6'h0A, 6'h0B, 6'h00};
  logic        clock_i = 1'b0;
  logic        rstn_i  = 1'b0;
  logic [4:0]  addr    = 5'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [7:0]  trig    = 8'h00;
  logic        ack     = 1'b0;
  logic [31:0] rdata, q;
  logic        wreq, irq, pwr, smp, busy, gain_select, gbyp, temp, g;
  logic [9:0]  res;
  logic [5:0]  chan, c;
  logic [2:0]  refs, r;
  int          n_fail, total_checks, cycles, run_len, last_len, last_smp, n_conv, n_smp, gap, last_gap, k;
  int          seen_smp = -1;
  int          seed     = 32'heb0a_108a;

  always #2.5 clock_i = ~clock_i;

  adcseq_top #(.N_TRIG(8)) DUT (
    .clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'h3), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .trig_i(trig), .irq_ack_i(ack), .irq_req_o(irq), .result_i(res), .power_on_o(pwr), .sample_o(smp),
    .conv_busy_o(busy), .channel_o(chan), .reference_o(refs), .gain_select_o(gain_select),
    .gain_bypass_o(gbyp), .temp_sensor_o(temp));

  adcseq_conv_model MODEL (.clock_i(clock_i), .rstn_i(rstn_i), .power_on_i(pwr), .sample_i(smp),
    .channel_i(chan), .result_o(res));

  // ------
  // Monitor: conversion length, sample position, sample spacing
  // ------
  always @(negedge clock_i) begin
    gap++;
    if (smp === 1'b1) begin
      if (busy === 1'b1 && seen_smp < 0) begin
        seen_smp = run_len;
      end
      last_gap = gap;
      gap = 0;
      n_smp++;
    end
    if (busy === 1'b1) begin
      run_len++;
    end else if (run_len > 0) begin
      last_len = run_len;
      last_smp = seen_smp;
      seen_smp = -1;
      run_len = 0;
      n_conv++;
    end
  end

  // Ceiling is well over ten times the expected run
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Request stands until the edge where waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    @(posedge clock_i);
    while (wreq !== 1'b0) @(posedge clock_i);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string what);
    bus(a, 1'b0, 32'h0000_0000);
    check(q, e, what);
  endtask

  task automatic wait_conv(input int n);
    while (n_conv < n) @(negedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask

  function automatic logic [15:0] exp_res(input logic [5:0] ch, input logic left);
    logic [9:0] v;
    v = {ch, ~ch[3:0]};
    return left ? {v, 6'h00} : {6'h00, v};
  endfunction

  function automatic logic [31:0] mux(input logic [5:0] ch, input logic left, input logic [2:0] rf);
    return {21'h0, rf, 1'b0, left, ch};
  endfunction

  task automatic rd_res(input logic [5:0] ch, input logic left);
    logic [15:0] e;
    e = exp_res(ch, left);
    rd_chk(ADDR_RES_LOW, 32'(e[7:0]), "low byte");
    rd_chk(ADDR_RES_HI, 32'(e[15:8]), "high byte");
  endtask

  task automatic conv(input logic [5:0] ch, input logic left);
    bus(ADDR_MUXSEL, 1'b1, mux(ch, left, 3'h0));
    bus(ADDR_CTRL_A, 1'b1, RUN | STRT);
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(ADR[i], 32'h0000_0000, "reset or unmapped");
    end
    check(32'({pwr, gbyp}), 32'h0000_0001, "reset outputs");
    bus(ADDR_MUXSEL, 1'b1, mux(6'h05, 1'b0, 3'h2));
    repeat (4) @(posedge clock_i);
    check(32'(chan), 32'h0000_0000, "held while off");
    bus(ADDR_CTRL_A, 1'b1, RUN);
    repeat (4) @(posedge clock_i);
    check(32'({pwr, chan, refs}), 32'({1'b1, 6'h05, 3'h2}), "applied on enable");
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? COR[i] : 6'($random(seed));
      r = 3'($random(seed));
      g = 1'($random(seed));
      bus(ADDR_CTRL_B, 1'b1, {27'h0, g, 4'h1});
      bus(ADDR_MUXSEL, 1'b1, mux(c, 1'b0, r));
      repeat (4) @(posedge clock_i);
      check(32'({chan, refs, gain_select}), 32'({c, r, g}), "selection");
      check(32'({temp, gbyp}), 32'({c == CH_TEMP_SENSOR, (c < CH_SE_COUNT) || (c == CH_TEMP_SENSOR)}), "kind");
    end
    conv(6'h07, 1'b0);
    rd_chk(ADDR_CTRL_A, RUN | STRT, "busy start bit");
    wait_conv(1);
    check(32'(last_len), 32'(25 * DIV), "first length");
    check(32'(last_smp), 32'(14 * DIV + DIV / 2), "first sample");
    check(32'(irq), 32'h0000_0001, "flag set");
    rd_chk(ADDR_CTRL_A, RUN | CLR, "start cleared");
    rd_res(6'h07, 1'b0);
    bus(ADDR_CTRL_A, 1'b1, RUN | CLR);
    @(posedge clock_i);
    check(32'(irq), 32'h0000_0000, "flag write clear");
    conv(6'h2C, 1'b1);
    wait_conv(2);
    check(32'(last_len), 32'(13 * DIV), "normal length");
    check(32'(last_smp), 32'(DIV + DIV / 2), "normal sample");
    rd_res(6'h2C, 1'b1);
    ack <= 1'b1;
    @(posedge clock_i);
    ack <= 1'b0;
    repeat (2) @(posedge clock_i);
    check(32'(irq), 32'h0000_0000, "flag ack clear");
    conv(6'h13, 1'b1);
    rd_chk(ADDR_RES_LOW, 32'(exp_res(6'h2C, 1'b1) & 16'h00FF), "lock read");
    wait_conv(3);
    check(32'(irq), 32'h0000_0001, "flag while locked");
    rd_res(6'h2C, 1'b1);
    bus(ADDR_CTRL_A, 1'b1, RUN | CLR);
    conv(6'h21, 1'b0);
    repeat (12) @(posedge clock_i);
    bus(ADDR_MUXSEL, 1'b1, mux(6'h09, 1'b0, 3'h0));
    // Give an unfrozen selection time to show through
    repeat (2) @(posedge clock_i);
    check(32'(chan), 32'h0000_0021, "frozen channel");
    wait_conv(4);
    check(32'(chan), 32'h0000_0009, "channel after end");
    rd_res(6'h21, 1'b0);
    for (int s = 1; s < 8; s++) begin
      bus(ADDR_CTRL_B, 1'b1, 32'(s));
      bus(ADDR_CTRL_A, 1'b1, RUN | AUTO | CLR);
      k = n_conv;
      trig <= 8'(1 << s);
      wait_conv(k + 1);
      check(32'(irq), 32'h0000_0001, "triggered flag");
      check(32'(last_smp), 32'(2 * DIV), "auto sample");
    end
    trig <= 8'h00;
    bus(ADDR_CTRL_A, 1'b1, RUN | AUTO | CLR);
    k = n_conv;
    trig <= 8'h80;
    while (busy !== 1'b1) @(negedge clock_i);
    rd_chk(ADDR_CTRL_A, RUN | AUTO | STRT, "auto busy bit");
    trig <= 8'h00;
    @(posedge clock_i);
    trig <= 8'h80;
    wait_conv(k + 1);
    repeat (300) @(posedge clock_i);
    check(32'(n_conv), 32'(k + 1), "no extra start");
    bus(ADDR_CTRL_A, 1'b1, RUN | AUTO | STRT);
    wait_conv(k + 2);
    bus(ADDR_CTRL_B, 1'b1, 32'(TRG_OWN_FLAG));
    bus(ADDR_CTRL_A, 1'b1, RUN | AUTO | STRT);
    k = n_smp;
    while (n_smp < k + 4) @(negedge clock_i);
    check(32'(last_gap), 32'(13 * DIV), "free run spacing");
    rd_chk(ADDR_CTRL_A, RUN | AUTO | STRT | CLR, "free run status");
    bus(ADDR_CTRL_A, 1'b1, 32'h0000_0000);
    repeat (2) @(posedge clock_i);
    check(32'({pwr, busy}), 32'h0000_0000, "disabled");
    complete_run();
  end
endmodule // adcseq_top_tb
